// file: tpg_controller.sv
// Operation
// - Controller stops all phase commands at once on the short fault flag.
// - Temperature flag handled by software; response drives commands low or raises a disable.
// - Fault latch set by short or temperature flag raises disable; software clears it.
// - Controller avoids zero and full duty while current limiting is in use.
// - Holding the limit pin at ground disables current limiting; outputs follow commands.
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module tpg_controller
  import tpg_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [DATA_W-1:0] rdata,
  output logic [2:0] top_side_cmd,
  output logic [2:0] bottom_side_cmd,
  output logic disable_b,
  input wire logic limit_flag_disable_a_i,
  output logic limit_flag_disable_a_o,
  output logic limit_flag_disable_a_oe_n,
  input wire logic short_fault_flag,
  input wire logic temp_flag
);

  if (CW < 2 || CW > DATA_W) begin : g_chk
    $error("tpg_controller: counter width must lie between 2 and the data width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [DATA_W-1:0] ctrl_reg;
  logic [CW-1:0] period_reg;
  logic [CW-1:0] duty_reg [3];
  logic [5:0] mode_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic short_seen_reg;
  logic temp_seen_reg;
  logic latch_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  tpg_state_type state_reg;
  tpg_state_type state_next;
  tpg_flags_type flags;
  tpg_phase_cmd_type phase_cmd [3];

  wire run_en = ctrl_reg[CTRL_RUN_BIT];
  wire limit_en = ctrl_reg[CTRL_LIMIT_EN_BIT];
  wire temp_auto = ctrl_reg[CTRL_TEMP_AUTO_BIT];
  wire latch_en = ctrl_reg[CTRL_LATCH_EN_BIT];
  wire dis_b_sw = ctrl_reg[CTRL_DIS_B_BIT];

  assign flags.short_fault_flag = short_fault_flag;
  assign flags.temp_flag = temp_flag;
  assign flags.limit_level = limit_flag_disable_a_i;

  // Address decode and write strobes
  wire wr_ctrl = wr_stb && (addr == CTRL_OFFSET);
  wire wr_period = wr_stb && (addr == PERIOD_OFFSET);
  wire wr_mode = wr_stb && (addr == MODE_OFFSET);
  wire wr_clear = wr_stb && (addr == CLEAR_OFFSET);
  wire [2:0] wr_duty = {wr_stb && (addr == DUTY_C_OFFSET),
                        wr_stb && (addr == DUTY_B_OFFSET),
                        wr_stb && (addr == DUTY_A_OFFSET)};
  wire clr_latch = wr_clear && wdata[CLR_LATCH_BIT];
  wire clr_short = wr_clear && wdata[CLR_SHORT_BIT];
  wire clr_temp = wr_clear && wdata[CLR_TEMP_BIT];

  // Status word, unused bits read zero
  wire [DATA_W-1:0] status_word = {{(DATA_W-6){1'b0}}, flags.temp_flag, (state_reg == TPG_STOPPED), latch_reg,
                                   flags.limit_level, temp_seen_reg, short_seen_reg};

  // Read multiplexer, unmapped addresses read zero
  always_comb begin
    if (addr == CTRL_OFFSET) begin
      rdata_next = ctrl_reg;
    end else if (addr == PERIOD_OFFSET) begin
      rdata_next = DATA_W'(period_reg);
    end else if (addr == DUTY_A_OFFSET) begin
      rdata_next = DATA_W'(duty_reg[0]);
    end else if (addr == DUTY_B_OFFSET) begin
      rdata_next = DATA_W'(duty_reg[1]);
    end else if (addr == DUTY_C_OFFSET) begin
      rdata_next = DATA_W'(duty_reg[2]);
    end else if (addr == MODE_OFFSET) begin
      rdata_next = {{(DATA_W-6){1'b0}}, mode_reg};
    end else if (addr == STATUS_OFFSET) begin
      rdata_next = status_word;
    end else begin
      rdata_next = '0;
    end
  end

  // Software registers and read data
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
      period_reg <= CW'(PERIOD_RESET);
      mode_reg <= MODE_RESET;
      rdata_reg <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= wdata;
      if (wr_period) period_reg <= wdata[CW-1:0];
      if (wr_mode) mode_reg <= wdata[5:0];
      rdata_reg <= rd_stb ? rdata_next : '0;
    end
  end

  assign rdata = rdata_reg;

  // Duty registers, one per phase
  for (genvar i = 0; i < 3; i++) begin : g_duty
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        duty_reg[i] <= CW'(DUTY_RESET);
      end else if (wr_duty[i]) begin
        duty_reg[i] <= wdata[CW-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault handling

  // Sticky flags and fault latch; a new event wins over a clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      short_seen_reg <= 1'b0;
      temp_seen_reg <= 1'b0;
      latch_reg <= 1'b0;
    end else begin
      short_seen_reg <= flags.short_fault_flag || (short_seen_reg && !clr_short);
      temp_seen_reg <= flags.temp_flag || (temp_seen_reg && !clr_temp);
      latch_reg <= (latch_en && (flags.short_fault_flag || flags.temp_flag)) || (latch_reg && !clr_latch);
    end
  end

  // Run state: a short fault stops commands until software clears it
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TPG_IDLE: begin
        if (run_en && !short_seen_reg) state_next = TPG_RUN;
      end
      TPG_RUN: begin
        if (flags.short_fault_flag) state_next = TPG_STOPPED;
        else if (!run_en) state_next = TPG_IDLE;
      end
      TPG_STOPPED: begin
        if (clr_short && !flags.short_fault_flag) state_next = TPG_IDLE;
      end
      default: state_next = TPG_IDLE;
    endcase
  end

  // PWM period counter
  assign count_next = (count_reg >= period_reg - CW'(1)) ? '0 : count_reg + CW'(1);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= TPG_IDLE;
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      count_reg <= (state_reg == TPG_RUN) ? count_next : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase commands

  for (genvar i = 0; i < 3; i++) begin : g_phase
    tpg_phase_pwm #(
      .CW(CW)
    ) u_pwm (
      .ref_clk(ref_clk),
      .reset(reset),
      .count(count_reg),
      .period(period_reg),
      .duty(duty_reg[i]),
      .mode(tpg_mode_type'(mode_reg[2*i +: 2])),
      .limit_en(limit_en),
      .cmd(phase_cmd[i])
    );
  end

  // Commands drop in the same cycle as a short flag or a temperature stop
  wire cmd_gate = (state_reg == TPG_RUN) && !flags.short_fault_flag && !(temp_auto && temp_seen_reg);

  for (genvar i = 0; i < 3; i++) begin : g_out
    assign top_side_cmd[i] = phase_cmd[i].top && cmd_gate;
    assign bottom_side_cmd[i] = phase_cmd[i].bottom && cmd_gate;
  end

  // Second disable: software request or fault latch
  assign disable_b = dis_b_sw || latch_reg;

  // Limit pin: driven high by the fault latch, held low to disable limiting, else released
  assign limit_flag_disable_a_o = latch_reg;
  assign limit_flag_disable_a_oe_n = !(latch_reg || !limit_en);

endmodule

// file: tpg_pkg.sv
package tpg_pkg;

  // Register map of the controller, byte addresses four apart on the software port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] PERIOD_OFFSET = 8'h04;
  localparam logic [7:0] DUTY_A_OFFSET = 8'h08;
  localparam logic [7:0] DUTY_B_OFFSET = 8'h0c;
  localparam logic [7:0] DUTY_C_OFFSET = 8'h10;
  localparam logic [7:0] MODE_OFFSET = 8'h14;
  localparam logic [7:0] STATUS_OFFSET = 8'h18;
  localparam logic [7:0] CLEAR_OFFSET = 8'h1c;

  // Control field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_LIMIT_EN_BIT = 1;
  localparam int CTRL_TEMP_AUTO_BIT = 2;
  localparam int CTRL_LATCH_EN_BIT = 3;
  localparam int CTRL_DIS_B_BIT = 4;

  // Clear field positions
  localparam int CLR_LATCH_BIT = 0;
  localparam int CLR_SHORT_BIT = 1;
  localparam int CLR_TEMP_BIT = 2;

  // Status field positions
  localparam int ST_SHORT_BIT = 0;
  localparam int ST_TEMP_BIT = 1;
  localparam int ST_LIMIT_BIT = 2;
  localparam int ST_LATCH_BIT = 3;
  localparam int ST_STOP_BIT = 4;
  localparam int ST_TEMP_NOW_BIT = 5;

  // Reset values
  localparam logic [15:0] CTRL_RESET = 16'h0002;
  localparam logic [15:0] PERIOD_RESET = 16'h03e8;
  localparam logic [15:0] DUTY_RESET = 16'h0000;
  localparam logic [5:0] MODE_RESET = 6'h00;

  // Per-phase drive modes
  typedef enum logic [1:0] {
    TPG_MODE_OFF = 2'b00,
    TPG_MODE_TOP_PWM = 2'b01,
    TPG_MODE_COMP_PWM = 2'b10,
    TPG_MODE_BOTTOM_ON = 2'b11
  } tpg_mode_type;

  // Controller state, Gray coded along idle, run, stopped
  typedef enum logic [1:0] {
    TPG_IDLE = 2'b00,
    TPG_RUN = 2'b01,
    TPG_STOPPED = 2'b11
  } tpg_state_type;

  // Commands to one half bridge
  typedef struct packed {
    logic top;
    logic bottom;
  } tpg_phase_cmd_type;

  // Flags returned by the driver
  typedef struct packed {
    logic short_fault_flag;
    logic temp_flag;
    logic limit_level;
  } tpg_flags_type;

endpackage

// file: tpg_phase_pwm.sv
`timescale 1ns/100ps
module tpg_phase_pwm
  import tpg_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [CW-1:0] count,
  input wire logic [CW-1:0] period,
  input wire logic [CW-1:0] duty,
  input wire tpg_mode_type mode,
  input wire logic limit_en,
  output tpg_phase_cmd_type cmd
);

  if (CW < 2) begin : g_chk
    $error("tpg_phase_pwm: counter width below 2");
  end

  logic [CW-1:0] duty_low;
  logic [CW-1:0] duty_high;
  logic [CW-1:0] duty_eff;
  logic top_on;
  tpg_phase_cmd_type cmd_next;
  tpg_phase_cmd_type cmd_reg;

  // Keep every period with a top rising edge when limiting is in use
  assign duty_low = (duty == '0) ? CW'(1) : duty;
  assign duty_high = (duty_low >= period) ? period - CW'(1) : duty_low;
  assign duty_eff = limit_en ? duty_high : duty;
  assign top_on = (count < duty_eff);

  // Mode selection of the two commands
  assign cmd_next.top = (mode == TPG_MODE_TOP_PWM || mode == TPG_MODE_COMP_PWM) && top_on;
  assign cmd_next.bottom = (mode == TPG_MODE_BOTTOM_ON) || (mode == TPG_MODE_COMP_PWM && !top_on);

  // Registered commands
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd_reg <= '0;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  assign cmd = cmd_reg;

endmodule

// file: tpg_controller_asserts.sv
`timescale 1ns/100ps
module tpg_controller_chk
  import tpg_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [2:0] top_side_cmd,
  input wire logic [2:0] bottom_side_cmd,
  input wire logic disable_b,
  input wire logic limit_flag_disable_a_i,
  input wire logic limit_flag_disable_a_o,
  input wire logic limit_flag_disable_a_oe_n,
  input wire logic short_fault_flag,
  input wire logic temp_flag
);
  logic latch_en_reg;
  wire ctrl_wr = wr_stb && addr == CTRL_OFFSET;
  // Shadow of the latch enable bit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      latch_en_reg <= 1'b0;
    end else if (ctrl_wr) begin
      latch_en_reg <= wdata[CTRL_LATCH_EN_BIT];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  a_short_stop: assert property (short_fault_flag |-> top_side_cmd == 3'h0 && bottom_side_cmd == 3'h0)
    else $error("commands live during short flag");
  a_short_hold: assert property ($fell(short_fault_flag) |-> (top_side_cmd == 3'h0)[*2])
    else $error("commands resumed without clear");
  a_read_gap: assert property (!$past(rd_stb) |-> rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_bad_addr: assert property (rd_stb && addr == 8'h20 |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_latch_set: assert property (latch_en_reg && (short_fault_flag || temp_flag) |-> ##[1:2] limit_flag_disable_a_o)
    else $error("fault latch not set");
  a_latch_out: assert property (limit_flag_disable_a_o |-> disable_b && !limit_flag_disable_a_oe_n)
    else $error("latch not driving disables");
  a_dis_b_set: assert property (ctrl_wr && wdata[CTRL_DIS_B_BIT] |=> disable_b)
    else $error("second disable not raised");
  a_limit_off: assert property (ctrl_wr && !wdata[CTRL_LIMIT_EN_BIT] |=> !limit_flag_disable_a_oe_n)
    else $error("limit pin not held");
  c_short: cover property ($rose(short_fault_flag));
  c_latch: cover property ($rose(limit_flag_disable_a_o));
  c_pin: cover property ($rose(limit_flag_disable_a_i) && limit_flag_disable_a_oe_n);
endmodule

bind tpg_controller tpg_controller_chk #(.CW(CW)) chk (.*);

// file: tpg_drv_model.sv
`timescale 1ns/100ps
module tpg_drv_model (
  input wire logic [2:0] top_side_cmd,
  input wire logic [2:0] bottom_side_cmd,
  input wire logic disable_b,
  input wire logic lim_pin,
  input wire logic [2:0] sense_over,
  input wire logic [1:0] supply_ok,
  input wire logic short_req,
  input wire integer die_temp,
  output logic short_fault_flag,
  output logic temp_flag,
  output logic lim_drive,
  output logic [2:0] phase_on
);
  int trip_ph = 0;
  logic armed = 1'b0;
  logic [2:0] top_d = 3'h0;
  logic [2:0] bot_d = 3'h0;
  logic [2:0] dead = 3'h0;
  // Faults only reported; no lockout status output exists
  assign short_fault_flag = short_req;
  assign phase_on = (top_side_cmd ^ bottom_side_cmd) & ~dead & {3{!disable_b && !lim_pin && &supply_ok}};
  // Both transistors of a phase held off briefly when top and bottom switch together
  always @(top_side_cmd or bottom_side_cmd) begin
    dead = (top_side_cmd ^ top_d) & (bottom_side_cmd ^ bot_d);
    top_d = top_side_cmd;
    bot_d = bottom_side_cmd;
    #5 dead = 3'h0;
  end
  initial lim_drive = 1'b0;
  // Wide temperature hysteresis
  initial temp_flag = 1'b0;
  always @(die_temp) begin
    if (die_temp >= 135) begin
      temp_flag = 1'b1;
    end else if (die_temp < 95) begin
      temp_flag = 1'b0;
    end
  end
  // Trip on mirrored top current at any instant, arm once quiet
  always @(*) begin
    for (int i = 0; i < 3; i++) begin
      if (sense_over[i] && top_side_cmd[i] && !lim_drive) begin
        lim_drive = 1'b1;
        trip_ph = i;
        armed = 1'b0;
      end
    end
    if (lim_drive && sense_over == 3'h0 && !top_side_cmd[trip_ph]) begin
      armed = 1'b1;
    end
  end
  // Release on any top rising edge
  always @(posedge top_side_cmd[0] or posedge top_side_cmd[1] or posedge top_side_cmd[2]) begin
    if (armed) begin
      lim_drive = 1'b0;
      armed = 1'b0;
    end
  end
endmodule

// file: tpg_controller_tb_top.sv
`timescale 1ns/100ps
module tpg_controller_tb_top
  import tpg_pkg::*;
;
  logic ref_clk, reset, wr_stb, rd_stb, disable_b, short_req, short_fault_flag, temp_flag, lim_drive;
  logic limit_flag_disable_a_o, limit_flag_disable_a_oe_n;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, rd_val;
  logic [2:0] top_side_cmd, bottom_side_cmd, sense_over, phase_on;
  logic [1:0] supply_ok = 2'b11;
  logic [15:0] rst_tab [9] = '{CTRL_RESET, PERIOD_RESET, DUTY_RESET, DUTY_RESET, DUTY_RESET, {10'h000, MODE_RESET},
                               16'h0000, 16'h0000, 16'h0000};
  int die_temp, n_fail, cmp_count, p;
  // Shared pin: controller drive wins over the latch resistor
  wire limit_flag_disable_a_i = !limit_flag_disable_a_oe_n ? limit_flag_disable_a_o : lim_drive;
  wire lim_pin = limit_flag_disable_a_i;
  tpg_controller #(.CW(16)) dut (.*);
  tpg_drv_model drv (.*);
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] exp);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(negedge ref_clk);
    rd_val = rdata;
    @(posedge ref_clk);
    check(rd_val, exp);
  endtask
  // Count phase A highs over two periods against the clamped duty
  task automatic pwm(input int m, input int dv);
    int e, nt, nb;
    wr(MODE_OFFSET, 16'(m));
    wr(DUTY_A_OFFSET, 16'(dv));
    repeat (p) @(posedge ref_clk);
    nt = 0;
    nb = 0;
    repeat (2 * p) begin
      @(negedge ref_clk);
      nt += top_side_cmd[0];
      nb += bottom_side_cmd[0];
    end
    @(posedge ref_clk);
    e = dv < 1 ? 1 : (dv > p - 1 ? p - 1 : dv);
    check(16'(nt), 16'(m == 1 || m == 2 ? 2 * e : 0));
    check(16'(nb), 16'(m == 3 ? 2 * p : (m == 2 ? 2 * (p - e) : 0)));
  endtask
  task automatic print_verdict();
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (8000) @(posedge ref_clk);
    n_fail++;
    print_verdict();
  end
  // Main sequence
  initial begin
    {reset, wr_stb, rd_stb, short_req} = 4'hf;
    {wr_stb, rd_stb, short_req} = 3'h0;
    {addr, wdata, sense_over} = '0;
    die_temp = 25;
    n_fail = 0;
    cmp_count = 0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    p = $urandom(84);
    for (int i = 0; i < 9; i++) rc(8'(i * 4), rst_tab[i]);
    p = 8 + $urandom % 16;
    wr(PERIOD_OFFSET, 16'(p));
    wr(CTRL_OFFSET, 16'h0003);
    for (int m = 0; m < 4; m++) pwm(m, 1 + $urandom % (p - 1));
    pwm(1, 0);
    pwm(1, p);
    short_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    short_req <= 1'b0;
    rc(STATUS_OFFSET, 16'h0011);
    wr(CLEAR_OFFSET, 16'h0002);
    rc(STATUS_OFFSET, 16'h0000);
    pwm(1, 5);
    wr(CTRL_OFFSET, 16'h000f);
    die_temp <= 140;
    repeat (3) @(posedge ref_clk);
    check(16'(disable_b), 16'h0001);
    check(16'(phase_on), 16'h0000);
    rc(STATUS_OFFSET, 16'h002e);
    die_temp <= 120;
    rc(STATUS_OFFSET, 16'h002e);
    die_temp <= 90;
    wr(CLEAR_OFFSET, 16'h0005);
    rc(STATUS_OFFSET, 16'h0000);
    check(16'(disable_b), 16'h0000);
    for (int k = 0; k < 2; k++) begin
      wr(CTRL_OFFSET, k ? 16'h0001 : 16'h0003);
      // Trip one cycle after a top rising edge, while the top command still stands high
      for (int i = 0; i < 40 && top_side_cmd[0]; i++) @(negedge ref_clk);
      for (int i = 0; i < 40 && !top_side_cmd[0]; i++) @(negedge ref_clk);
      @(posedge ref_clk);
      sense_over <= 3'h1;
      rc(STATUS_OFFSET, k ? 16'h0000 : 16'h0004);
      check(16'(phase_on), k ? 16'h0001 : 16'h0000);
      sense_over <= 3'h0;
      repeat (3 * p) @(posedge ref_clk);
      rc(STATUS_OFFSET, 16'h0000);
    end
    // Supply lockout on the phase B and C supply turns every phase off
    wr(MODE_OFFSET, 16'h0003);
    supply_ok <= 2'b01;
    rc(STATUS_OFFSET, 16'h0000);
    check(16'(phase_on), 16'h0000);
    supply_ok <= 2'b11;
    @(posedge ref_clk);
    check(16'(phase_on), 16'h0001);
    wr(CTRL_OFFSET, 16'h0013);
    check(16'(disable_b), 16'h0001);
    print_verdict();
  end
endmodule
